// [rtl/ifa_top.sv]
// input function allocator: routes eight contact inputs to internal
// functions per control mode, checks allocations, AHB-Lite slave
// assumes pin inputs synchronous to hclk; 1 = pin shorted to common
//
// Our own choices: the AHB-Lite register port and the register addresses.
`default_nettype none
`include "ifa_regs.svh"
module ifa_top
    import ifa_pkg::*;
(
    input  wire logic                     hclk,
    input  wire logic                     hresetn,
    input  wire logic                     hsel,
    input  wire logic [31:0]              haddr,
    input  wire logic [1:0]               htrans,
    input  wire logic                     hwrite,
    input  wire logic [2:0]               hsize,
    input  wire logic [31:0]              hwdata,
    input  wire logic                     hready,
    output logic                          hreadyout,
    output logic                          hresp,
    output logic [31:0]                   hrdata,
    input  wire logic [`IFA_NUM_PINS-1:0] control_input_pin,
    output ifa_func_type                  func_active,
    output logic [`IFA_NUM_PINS-1:0]      unallocated_pin,
    output ifa_alarm_type                 alarm_active,
    output logic                          irq
);

    localparam ifa_state_type RST_STATE = '{
        sel:     {`IFA_RST_SEL8, `IFA_RST_SEL7, `IFA_RST_SEL6, `IFA_RST_SEL5,
                  `IFA_RST_SEL4, `IFA_RST_SEL3, `IFA_RST_SEL2, `IFA_RST_SEL1},
        mode:    IFA_MODE_POSITION,
        default: '0
    };

    ifa_state_type s_reg;
    ifa_state_type s_next;

    // normally-closed form is the open code with bit 7 set
    function automatic ifa_code_type ifa_decode(input logic [7:0] c);
        ifa_code_type d;
        logic [7:0]   base;
        base       = c & ~`IFA_NC_FLAG;
        d.valid    = 1'b1;
        d.assigned = 1'b1;
        d.nc       = c[7];
        d.idx      = 4'h0;
        case (base)
            `IFA_FN_NONE: begin
                d.assigned = 1'b0;
                d.valid    = ~c[7];
            end
            `IFA_FN_FWD_PROH: d.idx = `IFA_IX_FWD_PROH;
            `IFA_FN_REV_PROH: d.idx = `IFA_IX_REV_PROH;
            `IFA_FN_ESTOP:    d.idx = `IFA_IX_ESTOP;
            `IFA_FN_ORIGIN:   d.idx = `IFA_IX_ORIGIN;
            `IFA_FN_LATCH_A: begin
                d.idx   = `IFA_IX_LATCH_A;
                d.valid = ~c[7];
            end
            `IFA_FN_LATCH_B: begin
                d.idx   = `IFA_IX_LATCH_B;
                d.valid = ~c[7];
            end
            `IFA_FN_LATCH_C: begin
                d.idx   = `IFA_IX_LATCH_C;
                d.valid = ~c[7];
            end
            `IFA_FN_FWD_TL:   d.idx = `IFA_IX_FWD_TL;
            `IFA_FN_REV_TL:   d.idx = `IFA_IX_REV_TL;
            `IFA_FN_MON_A:    d.idx = `IFA_IX_MON_A;
            `IFA_FN_MON_B:    d.idx = `IFA_IX_MON_B;
            `IFA_FN_MON_C:    d.idx = `IFA_IX_MON_C;
            default: begin
                d.valid    = 1'b0;
                d.assigned = 1'b0;
            end
        endcase
        return d;
    endfunction : ifa_decode

    // byte m of a selection word holds the code of mode m
    function automatic logic [7:0] ifa_code(input logic [`IFA_SEL_BITS-1:0] w, input int m);
        return w[m*`IFA_CODE_BITS +: `IFA_CODE_BITS];
    endfunction : ifa_code

    function automatic logic [31:0] ifa_read(input ifa_state_type s, input logic [5:0] idx);
        logic [31:0] r;
        r = 32'h00000000;
        if (idx < 6'(`IFA_NUM_PINS)) begin
            r[`IFA_SEL_BITS-1:0] = s.sel[idx[2:0]];
        end else begin
            case ({idx, 2'b00})
                `IFA_OFF_STATUS:  r[2:0] = s.status;
                `IFA_OFF_MASK:    r[2:0] = s.mask;
                `IFA_OFF_MODE:    r[1:0] = s.mode;
                `IFA_OFF_LIVE:    r[2:0] = s.live;
                `IFA_OFF_PINSTAT: begin
                    r[`IFA_NUM_PINS-1:0] = s.unalloc;
                    r[`IFA_PINSTAT_FUNC +: `IFA_NUM_FUNCS] = s.func;
                end
                default: r = 32'h00000000;
            endcase
        end
        return r;
    endfunction : ifa_read

    always_comb begin
        logic [`IFA_NUM_FUNCS-1:0][`IFA_NUM_PINS-1:0]  fpins;
        logic [`IFA_NUM_FUNCS-1:0][`IFA_NUM_MODES-1:0] fmodes;
        logic [`IFA_NUM_PINS-1:0][`IFA_NUM_FUNCS-1:0]  seen_no;
        logic [`IFA_NUM_PINS-1:0][`IFA_NUM_FUNCS-1:0]  seen_nc;
        logic [`IFA_NUM_FUNCS-1:0]                     fa;
        logic [`IFA_NUM_PINS-1:0]                      ua;
        logic                                          inv;
        ifa_code_type                                  d;
        ifa_alarm_type                                 al;
        logic                                          hit;
        fpins   = '0;
        fmodes  = '0;
        seen_no = '0;
        seen_nc = '0;
        fa      = '0;
        ua      = '0;
        inv     = 1'b0;
        d       = '0;
        al      = '0;
        hit     = 1'b0;
        s_next  = s_reg;

        // data phase of a write; hready is always high from this slave
        if (s_reg.ph_valid && s_reg.ph_write && s_reg.ph_hit) begin
            if (s_reg.ph_idx < 6'(`IFA_NUM_PINS)) begin
                s_next.sel[s_reg.ph_idx[2:0]] = hwdata[`IFA_SEL_BITS-1:0];
            end else begin
                case ({s_reg.ph_idx, 2'b00})
                    `IFA_OFF_STATUS: s_next.status = s_reg.status & ~ifa_alarm_type'(hwdata[2:0]);
                    `IFA_OFF_MASK:   s_next.mask   = ifa_alarm_type'(hwdata[2:0]);
                    // the reserved mode value is refused, mode stays
                    `IFA_OFF_MODE: begin
                        if (hwdata[1:0] != 2'b11) begin
                            s_next.mode = ifa_mode_type'(hwdata[1:0]);
                        end
                    end
                    default: s_next.status = s_next.status;
                endcase
            end
        end
        // a live alarm re-sets its flag even in the clearing cycle
        s_next.status = s_next.status | s_reg.live;

        // allocation check over all modes, from the stored settings
        for (int p = 0; p < `IFA_NUM_PINS; p++) begin
            for (int m = 0; m < `IFA_NUM_MODES; m++) begin
                d = ifa_decode(ifa_code(s_reg.sel[p], m));
                if (!d.valid) begin
                    inv = 1'b1;
                end else if (d.assigned) begin
                    fpins[d.idx][p]  = 1'b1;
                    fmodes[d.idx][m] = 1'b1;
                    if (d.nc) begin
                        seen_nc[p][d.idx] = 1'b1;
                    end else begin
                        seen_no[p][d.idx] = 1'b1;
                    end
                end
            end
        end
        for (int f = 0; f < `IFA_NUM_FUNCS; f++) begin
            // one function on two different pins, in any mode
            if ((fpins[f] & (fpins[f] - 8'h01)) != 8'h00) begin
                al.dup_alloc = 1'b1;
            end
        end
        for (int p = 0; p < `IFA_NUM_PINS; p++) begin
            if ((seen_no[p] & seen_nc[p]) != '0) begin
                al.func_number = 1'b1;
            end
        end
        al.func_number = al.func_number | inv;
        for (int f = 0; f < `IFA_NUM_FUNCS; f++) begin
            if (f == int'(`IFA_IX_LATCH_A) || f == int'(`IFA_IX_LATCH_B) || f == int'(`IFA_IX_LATCH_C)) begin
                if ((fpins[f] & ~`IFA_LATCH_PINS) != 8'h00) begin
                    al.latch_alloc = 1'b1;
                end
                if (fmodes[f] != 3'b000 && fmodes[f] != 3'b111) begin
                    al.latch_alloc = 1'b1;
                end
            end
        end
        s_next.live = al;

        // routing for the mode now in effect
        for (int p = 0; p < `IFA_NUM_PINS; p++) begin
            d = ifa_decode(ifa_code(s_reg.sel[p], int'(s_reg.mode)));
            if (d.valid && d.assigned) begin
                // contact logic: closed form is active with the pin open
                fa[d.idx] = fa[d.idx] | (control_input_pin[p] ^ d.nc);
            end else begin
                ua[p] = 1'b1;
            end
        end
        s_next.func    = ifa_func_type'(fa);
        s_next.unalloc = ua;

        // address phase; reads are captured from the next state so a write
        // committed in this cycle is seen by a read that follows it
        hit             = (haddr[31:8] == 24'h000000);
        s_next.ph_valid = hsel && htrans[1] && hready;
        s_next.ph_write = hwrite;
        s_next.ph_hit   = hit;
        s_next.ph_idx   = haddr[7:2];
        s_next.rdata    = 32'h00000000;
        if (hsel && htrans[1] && hready && !hwrite && hit) begin
            s_next.rdata = ifa_read(s_next, haddr[7:2]);
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s_reg <= RST_STATE;
        end else begin
            s_reg <= s_next;
        end
    end

    assign hreadyout       = 1'b1;
    assign hresp           = 1'b0;
    assign hrdata          = s_reg.rdata;
    assign func_active     = s_reg.func;
    assign unallocated_pin = s_reg.unalloc;
    assign alarm_active    = s_reg.live;
    assign irq             = |(s_reg.status & s_reg.mask);

    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    sequence s_sel0_write;
        hsel && htrans[1] && hready && hwrite && haddr == 32'h00000000
        ##1 1'b1;
    endsequence

    property p_sel_write;
        s_sel0_write |=> s_reg.sel[0] == $past(hwdata[`IFA_SEL_BITS-1:0]);
    endproperty
    a_sel_write: assert property (p_sel_write) else $error("selection write lost");

    property p_unassigned;
        ifa_code(s_reg.sel[7], int'(s_reg.mode)) == `IFA_FN_NONE
        |=> unallocated_pin[7];
    endproperty
    a_unassigned: assert property (p_unassigned) else $error("unassigned pin not flagged");

    property p_open_contact;
        s_reg.mode == IFA_MODE_SPEED && ifa_code(s_reg.sel[6], 1) == `IFA_FN_LATCH_A && control_input_pin[6]
        |=> func_active.latch_input_a;
    endproperty
    a_open_contact: assert property (p_open_contact) else $error("open contact not active");

    property p_closed_contact;
        s_reg.mode == IFA_MODE_POSITION && s_reg.sel[0][7:0] == (`IFA_FN_ESTOP | `IFA_NC_FLAG)
        && s_reg.sel[7][7:0] != (`IFA_FN_ESTOP | `IFA_NC_FLAG) && s_reg.sel[7][7:0] != `IFA_FN_ESTOP
        ##0 (control_input_pin[0] && control_input_pin[7])
        |=> func_active.emergency_stop == $past(!control_input_pin[0]);
    endproperty
    a_closed_contact: assert property (p_closed_contact) else $error("closed contact wrong");

    property p_latch_pin;
        s_reg.sel[7][7:0] == `IFA_FN_LATCH_A |=> alarm_active.latch_alloc ##1 s_reg.status.latch_alloc;
    endproperty
    a_latch_pin: assert property (p_latch_pin) else $error("latch pin alarm missing");

    property p_latch_modes;
        s_reg.sel[6][7:0] == `IFA_FN_LATCH_A && s_reg.sel[6][15:8] == `IFA_FN_NONE
        |=> alarm_active.latch_alloc;
    endproperty
    a_latch_modes: assert property (p_latch_modes) else $error("latch mode alarm missing");

    property p_duplicate;
        s_reg.sel[3][7:0] == `IFA_FN_MON_A && s_reg.sel[7][7:0] == `IFA_FN_MON_A
        |=> alarm_active.dup_alloc;
    endproperty
    a_duplicate: assert property (p_duplicate) else $error("duplicate alarm missing");

    property p_mixed_logic;
        s_reg.sel[3][7:0] == `IFA_FN_ORIGIN && s_reg.sel[3][15:8] == (`IFA_FN_ORIGIN | `IFA_NC_FLAG)
        |=> alarm_active.func_number;
    endproperty
    a_mixed_logic: assert property (p_mixed_logic) else $error("logic mismatch alarm missing");

    property p_invalid;
        s_reg.sel[7][7:0] == `IFA_NC_FLAG || s_reg.sel[7][7:0] == (`IFA_FN_LATCH_A | `IFA_NC_FLAG)
        |=> alarm_active.func_number;
    endproperty
    a_invalid: assert property (p_invalid) else $error("invalid code alarm missing");

    // a live alarm must reach the sticky flag even against a clear
    property p_live_sticky;
        s_reg.live != 3'b000 |=> (s_reg.status & $past(s_reg.live)) == $past(s_reg.live);
    endproperty
    a_live_sticky: assert property (p_live_sticky) else $error("live alarm not latched");

    sequence s_alarm_masked;
        s_reg.live.func_number && s_reg.mask.func_number ##1 s_reg.mask.func_number;
    endsequence

    property p_irq;
        s_alarm_masked |-> irq;
    endproperty
    a_irq: assert property (p_irq) else $error("interrupt level wrong");

    property p_reset_defaults;
        $rose(hresetn) |-> s_reg.sel[0] == `IFA_RST_SEL1 && s_reg.sel[4] == `IFA_RST_SEL5;
    endproperty
    a_reset_defaults: assert property (@(posedge hclk) p_reset_defaults) else $error("reset default wrong");

endmodule : ifa_top
`default_nettype wire

// [shared/ifa_regs.svh]
// constants of the input function allocator: offsets, codes, resets
// assumes byte addressing on AHB-Lite, one 32-bit word per register
// Operation
// - eight input pins, each with selection
// - one code per control mode, current applies
// - bit 7 set gives normally-closed form
// - normally open: shorted means active
// - normally closed: open means active
// - code 00h unassigned, no closed variant
// - prohibit forward 01h/81h, reverse 02h/82h
// - latches 20h, 21h, 2Bh, open only
// - torque limits 2Ch/ACh and 2Dh/ADh
// - monitors 2Eh/AEh, 2Fh/AFh, 30h/B0h
// - reset defaults per pin, all modes
// - unassigned pin flagged, drives nothing
// - same function on two pins raises duplicate alarm
// - latch outside pins 5-7 raises alarm
// - latch missing in some mode raises alarm
// - mixed logic across modes raises number alarm
`ifndef IFA_REGS_SVH
`define IFA_REGS_SVH

`define IFA_NUM_PINS      8
`define IFA_NUM_FUNCS     12
`define IFA_NUM_MODES     3
`define IFA_CODE_BITS     8
`define IFA_SEL_BITS      24
`define IFA_NC_FLAG       8'h80
`define IFA_LATCH_PINS    8'h70

`define IFA_OFF_SEL_BASE  8'h00
`define IFA_OFF_STATUS    8'h20
`define IFA_OFF_MASK      8'h24
`define IFA_OFF_MODE      8'h28
`define IFA_OFF_LIVE      8'h2C
`define IFA_OFF_PINSTAT   8'h30
`define IFA_PINSTAT_FUNC  8

`define IFA_RST_SEL1      24'h949494
`define IFA_RST_SEL2      24'h818181
`define IFA_RST_SEL3      24'h828282
`define IFA_RST_SEL4      24'h222222
`define IFA_RST_SEL5      24'h2B2B2B
`define IFA_RST_SEL6      24'h212121
`define IFA_RST_SEL7      24'h202020
`define IFA_RST_SEL8      24'h2E2E2E

`define IFA_FN_NONE       8'h00
`define IFA_FN_FWD_PROH   8'h01
`define IFA_FN_REV_PROH   8'h02
`define IFA_FN_ESTOP      8'h14
`define IFA_FN_LATCH_A    8'h20
`define IFA_FN_LATCH_B    8'h21
`define IFA_FN_ORIGIN     8'h22
`define IFA_FN_LATCH_C    8'h2B
`define IFA_FN_FWD_TL     8'h2C
`define IFA_FN_REV_TL     8'h2D
`define IFA_FN_MON_A      8'h2E
`define IFA_FN_MON_B      8'h2F
`define IFA_FN_MON_C      8'h30

`define IFA_IX_FWD_PROH   4'h0
`define IFA_IX_REV_PROH   4'h1
`define IFA_IX_ESTOP      4'h2
`define IFA_IX_LATCH_A    4'h3
`define IFA_IX_LATCH_B    4'h4
`define IFA_IX_ORIGIN     4'h5
`define IFA_IX_LATCH_C    4'h6
`define IFA_IX_FWD_TL     4'h7
`define IFA_IX_REV_TL     4'h8
`define IFA_IX_MON_A      4'h9
`define IFA_IX_MON_B      4'hA
`define IFA_IX_MON_C      4'hB

`endif

// [shared/ifa_pkg.sv]
// types of the input function allocator
// assumes ifa_regs.svh on the include path
`default_nettype none
`include "ifa_regs.svh"
package ifa_pkg;

    typedef enum logic [1:0] {
        IFA_MODE_POSITION,
        IFA_MODE_SPEED,
        IFA_MODE_TORQUE
    } ifa_mode_type;

    typedef struct packed {
        logic latch_alloc;
        logic func_number;
        logic dup_alloc;
    } ifa_alarm_type;

    typedef struct packed {
        logic monitor_input_c;
        logic monitor_input_b;
        logic monitor_input_a;
        logic reverse_torque_limit_input;
        logic forward_torque_limit_input;
        logic latch_input_c;
        logic origin_proximity_input;
        logic latch_input_b;
        logic latch_input_a;
        logic emergency_stop;
        logic reverse_drive_prohibit;
        logic forward_drive_prohibit;
    } ifa_func_type;

    typedef struct packed {
        logic       valid;
        logic       assigned;
        logic       nc;
        logic [3:0] idx;
    } ifa_code_type;

    typedef struct packed {
        logic [`IFA_NUM_PINS-1:0][`IFA_SEL_BITS-1:0] sel;
        ifa_mode_type                                mode;
        ifa_alarm_type                               status;
        ifa_alarm_type                               mask;
        ifa_alarm_type                               live;
        ifa_func_type                                func;
        logic [`IFA_NUM_PINS-1:0]                    unalloc;
        logic                                        ph_valid;
        logic                                        ph_write;
        logic                                        ph_hit;
        logic [5:0]                                  ph_idx;
        logic [31:0]                                 rdata;
    } ifa_state_type;

endpackage : ifa_pkg
`default_nettype wire

// [dv/ifa_contact_model.sv]
// contact model: switches and sensors wired against the input common
// assumes the bench commands which contacts are closed, one bit a pin
`default_nettype none
module ifa_contact_model (
    input  wire logic [7:0] contact_closed,
    output logic      [7:0] control_input_pin
);
    timeunit 1ns;
    timeprecision 100ps;
    // a closed contact shorts the input to common, which the block reads as 1
    assign control_input_pin = contact_closed;
endmodule : ifa_contact_model
`default_nettype wire

// [dv/testbench.sv]
// self-checking bench: AHB-Lite register tasks, contact model on the pins
// assumes ifa_top answers OKAY with the map of ifa_regs.svh
`default_nettype none
`include "ifa_regs.svh"
module testbench
    import ifa_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic          hclk, hresetn, hsel, hwrite, hreadyout, hresp, irq;
    logic [31:0]   haddr, hwdata, hrdata;
    logic [1:0]    htrans;
    logic [7:0]    contact_closed, unallocated_pin;
    wire  [7:0]    control_input_pin;
    ifa_func_type  func_active;
    ifa_alarm_type alarm_active;
    int            num_errors, samples_checked;
    localparam logic [23:0] RST_SEL [8] = '{24'h949494, 24'h818181, 24'h828282, 24'h222222,
                                            24'h2B2B2B, 24'h212121, 24'h202020, 24'h2E2E2E};
    localparam logic [7:0]  CODES [16] = '{8'h01, 8'h81, 8'h02, 8'h82, 8'h2C, 8'hAC, 8'h2D, 8'hAD,
                                           8'h2E, 8'hAE, 8'h2F, 8'hAF, 8'h30, 8'hB0, 8'h14, 8'h94};
    localparam int          IDX [16] = '{0, 0, 1, 1, 7, 7, 8, 8, 9, 9, 10, 10, 11, 11, 2, 2};
    // pin, selection value, expected alarms, alarm bits compared
    localparam int          A_PIN [6] = '{8, 8, 4, 4, 8, 7};
    localparam logic [31:0] A_VAL [6] = '{32'h002E2E80, 32'h00A0A0A0, 32'h002E2E2E, 32'h0022A222,
                                          32'h00202020, 32'h00000020};
    localparam logic [2:0]  A_EXP [6] = '{3'h2, 3'h2, 3'h1, 3'h2, 3'h4, 3'h4};
    localparam logic [2:0]  A_MSK [6] = '{3'h7, 3'h2, 3'h7, 3'h7, 3'h4, 3'h7};

    ifa_top u_dut (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
        .hrdata(hrdata), .control_input_pin(control_input_pin), .func_active(func_active),
        .unallocated_pin(unallocated_pin), .alarm_active(alarm_active), .irq(irq)
    );
    ifa_contact_model u_contacts (
        .contact_closed(contact_closed), .control_input_pin(control_input_pin)
    );

    initial begin
        hclk = 1'b0;
        forever #5 hclk = ~hclk;
    end

    task automatic end_of_test;
        $display("comparisons %0d, mismatches %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : end_of_test

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
        end
    endtask : check

    // address phase held until hready, then data phase; read data taken at its closing edge
    // every transfer starts on a rising edge; only the watchdog ends a wait
    task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rdat);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        hwrite <= wr;
        htrans <= 2'b10;
        do begin
            @(posedge hclk);
        end while (hreadyout !== 1'b1);
        htrans <= 2'b00;
        hsel <= 1'b0;
        hwdata <= wd;
        do begin
            @(posedge hclk);
        end while (hreadyout !== 1'b1);
        rdat = hrdata;
    endtask : ahb

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] x;
        ahb(1'b1, a, d, x);
    endtask : wr

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] x;
        ahb(1'b0, a, 32'h0, x);
        check(x, e);
    endtask : rd_chk

    // settings reach the outputs one edge after the write; status one more
    task automatic settle;
        repeat (3) @(posedge hclk);
        #1;
    endtask : settle

    task automatic pins(input logic [7:0] v);
        @(posedge hclk);
        contact_closed <= v;
        settle();
    endtask : pins

    function automatic logic [7:0] sel_a(input int p);
        return 8'(`IFA_OFF_SEL_BASE + 4 * (p - 1));
    endfunction : sel_a

    initial begin
        #50000;
        num_errors++;
        end_of_test();
    end

    initial begin
        hresetn = 1'b0;
        hsel = 1'b0;
        hwrite = 1'b0;
        htrans = 2'b00;
        haddr = 32'h0;
        hwdata = 32'h0;
        contact_closed = 8'h00;
        num_errors = 0;
        samples_checked = 0;
        repeat (4) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        for (int p = 1; p <= 8; p++) begin
            rd_chk(sel_a(p), {8'h00, RST_SEL[p-1]});
        end
        settle();
        check(32'(func_active), 32'h007);
        pins(8'hFF);
        check(32'(func_active), 32'h278);
        check({21'h0, alarm_active, unallocated_pin}, 32'h0);
        $display("test defaults finished");

        wr(sel_a(8), 32'hA52C002E);
        rd_chk(sel_a(8), 32'h002C002E);
        settle();
        check(32'(func_active), 32'h278);
        wr(`IFA_OFF_MODE, 32'h1);
        settle();
        check({12'(func_active), unallocated_pin}, {12'h078, 8'h80});
        wr(`IFA_OFF_MODE, 32'h2);
        settle();
        check({12'(func_active), unallocated_pin}, {12'h0F8, 8'h00});
        check(32'(alarm_active), 32'h0);
        wr(`IFA_OFF_MODE, 32'h3);
        rd_chk(`IFA_OFF_MODE, 32'h2);
        wr(`IFA_OFF_MODE, 32'h0);
        $display("test modes finished");

        // other pins shorted so their closed-contact functions stay off
        for (int i = 0; i < 16; i++) begin
            wr(sel_a(8), {8'h00, CODES[i], CODES[i], CODES[i]});
            for (int s = 0; s < 2; s++) begin
                pins({s[0], 7'h7F});
                check(32'(func_active[IDX[i]]), 32'(s[0] ^ CODES[i][7]));
            end
        end
        wr(sel_a(8), 32'h002E2E2E);
        pins(8'hFF);
        $display("test codes finished");

        for (int i = 0; i < 6; i++) begin
            wr(sel_a(A_PIN[i]), A_VAL[i]);
            settle();
            check(32'(alarm_active & A_MSK[i]), 32'(A_EXP[i]));
            wr(sel_a(A_PIN[i]), {8'h00, RST_SEL[A_PIN[i]-1]});
        end
        settle();
        check(32'(alarm_active), 32'h0);
        $display("test alarms finished");

        rd_chk(`IFA_OFF_STATUS, 32'h7);
        check(32'(irq), 32'h0);
        wr(`IFA_OFF_MASK, 32'h2);
        settle();
        check(32'(irq), 32'h1);
        wr(`IFA_OFF_STATUS, 32'h2);
        settle();
        check(32'(irq), 32'h0);
        rd_chk(`IFA_OFF_STATUS, 32'h5);
        wr(`IFA_OFF_STATUS, 32'h5);
        rd_chk(`IFA_OFF_STATUS, 32'h0);
        wr(sel_a(8), 32'h002E2E80);
        settle();
        check(32'(irq), 32'h1);
        rd_chk(`IFA_OFF_LIVE, 32'h2);
        rd_chk(`IFA_OFF_PINSTAT, 32'h00007880);
        wr(`IFA_OFF_LIVE, 32'h0);
        rd_chk(`IFA_OFF_LIVE, 32'h2);
        // set wins while the alarm is still live
        wr(`IFA_OFF_STATUS, 32'h2);
        rd_chk(`IFA_OFF_STATUS, 32'h2);
        wr(sel_a(8), 32'h002E2E2E);
        settle();
        wr(`IFA_OFF_STATUS, 32'h2);
        settle();
        check(32'(irq), 32'h0);
        wr(8'hFC, 32'hFFFFFFFF);
        rd_chk(8'hFC, 32'h0);
        check(32'(hresp), 32'h0);
        check(32'(hreadyout), 32'h1);
        $display("test registers finished");

        wr(sel_a(1), 32'h00000000);
        @(posedge hclk);
        hresetn <= 1'b0;
        repeat (4) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        rd_chk(sel_a(1), 32'h00949494);
        rd_chk(`IFA_OFF_MASK, 32'h0);
        $display("test second reset finished");
        end_of_test();
    end
endmodule : testbench
`default_nettype wire
